// ===== logic/pin_osc_irq_pkg.sv
/*
 * Shared constants of the pin, oscillator and interrupt configuration bank:
 * register offsets, field positions, writable masks, reset values and
 * timing counts.
 * Assumes an 8-bit register port and a 20 MHz core clock.
 */
`default_nettype none

package pin_osc_irq_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h01;
    localparam logic [7:0] ADDR_PIN_ALT = 8'h3C;
    localparam logic [7:0] ADDR_GENERAL = 8'h3D;
    localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h3E;
    localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h40;

    // ------------------------------------------------------------------
    // Writable bits and reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] PIN_ALT_MASK = 8'hF9;
    localparam logic [7:0] GENERAL_MASK = 8'hE7;
    localparam logic [7:0] IRQ_MASK = 8'h17;
    localparam logic [7:0] PIN_ALT_RESET = 8'h00;
    localparam logic [7:0] GENERAL_RESET = 8'h00;
    localparam logic [7:0] IRQ_ENABLE_RESET = 8'h00;
    localparam logic [7:0] IRQ_STATUS_RESET = 8'h00;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int PULL_100K_BIT = 7;
    localparam int COL0_ALT_BIT = 6;
    localparam int ROW4_ALT_BIT = 5;
    localparam int COL1_ALT_BIT = 4;
    localparam int ROW3_ALT_BIT = 3;
    localparam int ROW0_ALT_BIT = 0;
    localparam int OSC_ON_BIT = 7;
    localparam int CLK_SEL_MSB = 6;
    localparam int CLK_SEL_LSB = 5;
    localparam int SOFT_RESET_BIT = 2;
    localparam int RELEASE_ON_CLEAR_BIT = 1;
    localparam int RESET_PIN_IGNORE_BIT = 0;
    localparam int LOGIC_IRQ_BIT = 4;
    localparam int OVERFLOW_IRQ_BIT = 2;
    localparam int INPUT_CHANGE_IRQ_BIT = 1;
    localparam int EVENT_IRQ_BIT = 0;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_HZ = 20_000_000;
    localparam int BASE_OSC_HZ = 800_000;
    localparam int OSC_CYCLES = CLK_HZ / BASE_OSC_HZ;
    localparam int CORE_PERIOD_50K = OSC_CYCLES * 16;
    localparam int CORE_PERIOD_100K = OSC_CYCLES * 8;
    localparam int CORE_PERIOD_200K = OSC_CYCLES * 4;
    localparam int CORE_PERIOD_400K = OSC_CYCLES * 2;
    localparam int TICK_CNT_W = 9;
    localparam int RELEASE_TIME_US = 50;
    localparam int RELEASE_CYCLES = (RELEASE_TIME_US * (CLK_HZ / 1000)) / 1000;
    localparam int SOFT_RESET_WAIT_US = 200;

endpackage

`default_nettype wire

// ===== logic/alt_pin_mux.sv
/*
 * One pin's output selector: general-purpose drive or an alternate
 * function, registered so the pin sees no combinational glitch.
 * Assumes the select comes from a configuration register of the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module alt_pin_mux
(
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic alt_sel_in,
    input wire logic gpio_data_in,
    input wire logic gpio_oe_in,
    input wire logic alt_data_in,
    input wire logic alt_oe_in,
    output logic pin_data_out,
    output logic pin_oe_out
);

    logic pin_data_d;
    logic pin_oe_d;

    assign pin_data_d = alt_sel_in ? alt_data_in : gpio_data_in;
    assign pin_oe_d = alt_sel_in ? alt_oe_in : gpio_oe_in;

    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            pin_data_out <= 1'b0;
            pin_oe_out <= 1'b0;
        end
        else
        begin
            pin_data_out <= pin_data_d;
            pin_oe_out <= pin_oe_d;
        end
    end

endmodule

`default_nettype wire

// ===== logic/release_timer.sv
/*
 * Fixed-length busy window: busy from the start cycle for COUNT cycles.
 * Assumes start and clear are synchronous one-cycle or level strobes.
 */
`timescale 1ns/1ps
`default_nettype none

module release_timer
#(
    parameter int COUNT = 1000
)
(
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic clr_in,
    input wire logic start_in,
    output logic busy_out
);

    localparam int CNT_W = $clog2(COUNT + 1);
    localparam logic [CNT_W-1:0] LOAD = CNT_W'(COUNT - 1);

    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;

    assign cnt_d = clr_in ? '0 :
                   start_in ? LOAD :
                   (cnt_q != '0) ? cnt_q - 1'b1 : cnt_q;
    // Busy already in the start cycle so the pin releases on the next edge
    assign busy_out = start_in || (cnt_q != '0);

    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
            cnt_q <= '0;
        else
            cnt_q <= cnt_d;
    end

endmodule

`default_nettype wire

// ===== logic/pin_osc_irq_config_regs.sv
/*
 * Configuration bank for pin alternate functions, core clock divider,
 * software and pin reset, and interrupt status, enable and pin control.
 * Assumes a synchronous 8-bit register port with read data one cycle
 * after the read strobe, and synchronous event and pin inputs.
 */
// What this block does
// (R1) Pull-strength bit selects 300k (0) or 100k (1) row pull-up.
// (R2) Column 0 alternate bit routes pulse output one to the pin.
// (R3) Row 4 alternate bit turns the pin into the reset output.
// (R4) Column 1 alternate bit routes pulse output two to the pin.
// (R5) Row 3 alternate bit feeds the pin into logic input C.
// (R6) Row 0 alternate bit drives logic output Y onto the pin.
// (R7) Oscillator bit turns the base oscillator on or off.
// (R8) Clock select divides base oscillator to 50, 100, 200, 400 kHz.
// (R9) Writing one to the soft reset bit resets the device.
// (R10) Host waits at least 200 us after soft reset before reprogramming.
// (R11) Clear with interrupt pending: hold pin, or release 50 us.
// (R12) Reset pin low resets unless the ignore bit is set.
// (R13) Logic enable gates the logic status flag onto the pin.
// (R14) Overflow enable gates the overflow flag onto the pin.
// (R15) Input-change enable gates the input-change flag onto the pin.
// (R16) Event enable gates the event flag onto the pin.
// (R17) Interrupt pin is OR of each flag ANDed with its enable.
// (R18) Reserved bits read as zero and ignore writes.
`timescale 1ns/1ps
`default_nettype none

module pin_osc_irq_config_regs
    import pin_osc_irq_pkg::*;
#(
    parameter int RELEASE_COUNT = RELEASE_CYCLES
)
(
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic reset_pin_n_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    input wire logic logic_irq_event_in,
    input wire logic overflow_irq_event_in,
    input wire logic input_change_irq_event_in,
    input wire logic key_event_irq_in,
    input wire logic gpio1_data_in,
    input wire logic gpio1_oe_in,
    input wire logic logic_output_y_in,
    input wire logic gpio4_data_in,
    input wire logic gpio4_oe_in,
    input wire logic row3_pin_in,
    input wire logic gpio5_data_in,
    input wire logic gpio5_oe_in,
    input wire logic reset_gen_in,
    input wire logic gpio7_data_in,
    input wire logic gpio7_oe_in,
    input wire logic pulse_output_one_in,
    input wire logic gpio8_data_in,
    input wire logic gpio8_oe_in,
    input wire logic pulse_output_two_in,
    output logic row0_pin_out,
    output logic row0_oe_out,
    output logic row3_pin_out,
    output logic row3_oe_out,
    output logic row4_pin_out,
    output logic row4_oe_out,
    output logic col0_pin_out,
    output logic col0_oe_out,
    output logic col1_pin_out,
    output logic col1_oe_out,
    output logic logic_input_c_out,
    output logic gpio4_in_out,
    output logic row_pull_100k_out,
    output logic oscillator_on_out,
    output logic core_tick_out,
    output logic core_reset_out,
    output logic int_n_out
);

    // ------------------------------------------------------------------
    // Register port decode
    // ------------------------------------------------------------------
    logic [7:0] pin_alt_q;
    logic [7:0] pin_alt_d;
    logic [7:0] general_q;
    logic [7:0] general_d;
    logic [7:0] irq_en_q;
    logic [7:0] irq_en_d;
    logic [7:0] status_q;
    logic [7:0] status_d;
    logic [7:0] rdata_d;
    logic [7:0] clr_bits;
    logic [7:0] set_bits;
    logic soft_reset_bit_q;
    logic soft_reset_bit_d;
    logic sreset;
    logic wr_pin_alt;
    logic wr_general;
    logic wr_irq_en;
    logic wr_irq_clr;

    // A reset in progress swallows writes, so nothing survives it
    assign wr_pin_alt = reg_wr_in && !sreset && (reg_addr_in == ADDR_PIN_ALT);
    assign wr_general = reg_wr_in && !sreset && (reg_addr_in == ADDR_GENERAL);
    assign wr_irq_en = reg_wr_in && !sreset &&
                       (reg_addr_in == ADDR_IRQ_ENABLE);
    assign wr_irq_clr = reg_wr_in && !sreset &&
                        (reg_addr_in == ADDR_IRQ_CLEAR);

    // ------------------------------------------------------------------
    // Device reset sources
    // ------------------------------------------------------------------
    assign soft_reset_bit_d = wr_general && reg_wdata_in[SOFT_RESET_BIT]; // see (R9)
    assign sreset = soft_reset_bit_q || // see (R9)
                    (!reset_pin_n_in &&
                     !general_q[RESET_PIN_IGNORE_BIT]); // see (R12)

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------
    assign pin_alt_d = sreset ? PIN_ALT_RESET :
                       wr_pin_alt ? (reg_wdata_in & PIN_ALT_MASK) : // see (R18)
                       pin_alt_q;
    // Soft reset bit self-clears: it is a command, not a state
    assign general_d = sreset ? GENERAL_RESET :
                       wr_general ? (reg_wdata_in & GENERAL_MASK &
                                     ~(8'h01 << SOFT_RESET_BIT)) : // see (R18)
                       general_q;
    assign irq_en_d = sreset ? IRQ_ENABLE_RESET :
                      wr_irq_en ? (reg_wdata_in & IRQ_MASK) : // see (R18)
                      irq_en_q;

    // ------------------------------------------------------------------
    // Interrupt status: set wins over a clear in the same cycle
    // ------------------------------------------------------------------
    assign set_bits = (8'(logic_irq_event_in) << LOGIC_IRQ_BIT) |
                      (8'(overflow_irq_event_in) << OVERFLOW_IRQ_BIT) |
                      (8'(input_change_irq_event_in) << INPUT_CHANGE_IRQ_BIT) |
                      (8'(key_event_irq_in) << EVENT_IRQ_BIT);
    assign clr_bits = wr_irq_clr ? (reg_wdata_in & IRQ_MASK) : 8'h00;
    assign status_d = sreset ? IRQ_STATUS_RESET :
                      ((status_q & ~clr_bits) | set_bits);

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    assign rdata_d = !reg_rd_in ? 8'h00 :
                     (reg_addr_in == ADDR_PIN_ALT) ? pin_alt_q :
                     (reg_addr_in == ADDR_GENERAL) ? general_q :
                     (reg_addr_in == ADDR_IRQ_ENABLE) ? irq_en_q :
                     (reg_addr_in == ADDR_IRQ_STATUS) ? status_q :
                     8'h00;

    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            pin_alt_q <= PIN_ALT_RESET;
            general_q <= GENERAL_RESET;
            irq_en_q <= IRQ_ENABLE_RESET;
            status_q <= IRQ_STATUS_RESET;
            soft_reset_bit_q <= 1'b0;
            reg_rdata_out <= 8'h00;
            core_reset_out <= 1'b0;
        end
        else
        begin
            pin_alt_q <= pin_alt_d;
            general_q <= general_d;
            irq_en_q <= irq_en_d;
            status_q <= status_d;
            soft_reset_bit_q <= soft_reset_bit_d;
            reg_rdata_out <= rdata_d;
            core_reset_out <= sreset;
        end
    end

    // ------------------------------------------------------------------
    // Interrupt pin
    // ------------------------------------------------------------------
    logic pending;
    logic release_start;
    logic release_busy;
    logic int_n_d;

    assign pending = |(status_d & irq_en_d); // see (R13) (R14) (R15) (R16) (R17)
    // Only a clear that leaves something enabled pending releases the pin
    assign release_start = wr_irq_clr && pending &&
                           general_q[RELEASE_ON_CLEAR_BIT]; // see (R11)
    assign int_n_d = !(pending && !release_busy); // see (R11) (R17)

    release_timer #(
        .COUNT(RELEASE_COUNT)
    ) u_release_timer (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .clr_in(sreset),
        .start_in(release_start),
        .busy_out(release_busy)
    );

    // ------------------------------------------------------------------
    // Core clock divider and static controls
    // ------------------------------------------------------------------
    logic [TICK_CNT_W-1:0] tick_cnt_q;
    logic [TICK_CNT_W-1:0] tick_cnt_d;
    logic [TICK_CNT_W-1:0] core_period;
    logic [1:0] clk_sel;
    logic tick_d;

    assign clk_sel = general_q[CLK_SEL_MSB:CLK_SEL_LSB];
    assign core_period = (clk_sel == 2'h0) ? TICK_CNT_W'(CORE_PERIOD_50K) :
                         (clk_sel == 2'h1) ? TICK_CNT_W'(CORE_PERIOD_100K) :
                         (clk_sel == 2'h2) ? TICK_CNT_W'(CORE_PERIOD_200K) :
                         TICK_CNT_W'(CORE_PERIOD_400K); // see (R8)
    // A faster setting may find the count past its end: wrap at once
    assign tick_d = general_q[OSC_ON_BIT] &&
                    (tick_cnt_q >= core_period - 1'b1); // see (R7) (R8)
    assign tick_cnt_d = (!general_q[OSC_ON_BIT] || tick_d) ? '0 :
                        tick_cnt_q + 1'b1; // see (R7)

    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            tick_cnt_q <= '0;
            core_tick_out <= 1'b0;
            int_n_out <= 1'b1;
            oscillator_on_out <= 1'b0;
            row_pull_100k_out <= 1'b0;
            logic_input_c_out <= 1'b0;
            gpio4_in_out <= 1'b0;
        end
        else
        begin
            tick_cnt_q <= tick_cnt_d;
            core_tick_out <= tick_d;
            int_n_out <= int_n_d;
            oscillator_on_out <= general_d[OSC_ON_BIT]; // see (R7)
            row_pull_100k_out <= pin_alt_d[PULL_100K_BIT]; // see (R1)
            logic_input_c_out <= pin_alt_q[ROW3_ALT_BIT] &&
                                 row3_pin_in; // see (R5)
            gpio4_in_out <= !pin_alt_q[ROW3_ALT_BIT] && row3_pin_in;
        end
    end

    // ------------------------------------------------------------------
    // Pin alternate functions
    // ------------------------------------------------------------------
    alt_pin_mux u_row0 ( // see (R6)
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .alt_sel_in(pin_alt_q[ROW0_ALT_BIT]),
        .gpio_data_in(gpio1_data_in),
        .gpio_oe_in(gpio1_oe_in),
        .alt_data_in(logic_output_y_in),
        .alt_oe_in(1'b1),
        .pin_data_out(row0_pin_out),
        .pin_oe_out(row0_oe_out)
    );

    // As logic input the row 3 driver must let go of the pin
    alt_pin_mux u_row3 ( // see (R5)
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .alt_sel_in(pin_alt_q[ROW3_ALT_BIT]),
        .gpio_data_in(gpio4_data_in),
        .gpio_oe_in(gpio4_oe_in),
        .alt_data_in(1'b0),
        .alt_oe_in(1'b0),
        .pin_data_out(row3_pin_out),
        .pin_oe_out(row3_oe_out)
    );

    alt_pin_mux u_row4 ( // see (R3)
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .alt_sel_in(pin_alt_q[ROW4_ALT_BIT]),
        .gpio_data_in(gpio5_data_in),
        .gpio_oe_in(gpio5_oe_in),
        .alt_data_in(reset_gen_in),
        .alt_oe_in(1'b1),
        .pin_data_out(row4_pin_out),
        .pin_oe_out(row4_oe_out)
    );

    alt_pin_mux u_col0 ( // see (R2)
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .alt_sel_in(pin_alt_q[COL0_ALT_BIT]),
        .gpio_data_in(gpio7_data_in),
        .gpio_oe_in(gpio7_oe_in),
        .alt_data_in(pulse_output_one_in),
        .alt_oe_in(1'b1),
        .pin_data_out(col0_pin_out),
        .pin_oe_out(col0_oe_out)
    );

    alt_pin_mux u_col1 ( // see (R4)
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .alt_sel_in(pin_alt_q[COL1_ALT_BIT]),
        .gpio_data_in(gpio8_data_in),
        .gpio_oe_in(gpio8_oe_in),
        .alt_data_in(pulse_output_two_in),
        .alt_oe_in(1'b1),
        .pin_data_out(col1_pin_out),
        .pin_oe_out(col1_oe_out)
    );

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (rst_in);

    a_pull_strength: assert property ( // see (R1)
        wr_pin_alt |=> row_pull_100k_out == $past(reg_wdata_in[7]))
        else $error("row pull strength does not follow the written bit");

    a_col0_pulse: assert property ( // see (R2)
        pin_alt_q[COL0_ALT_BIT] |=>
            col0_oe_out && (col0_pin_out == $past(pulse_output_one_in)))
        else $error("column 0 does not carry pulse output one");

    a_row4_reset: assert property ( // see (R3)
        pin_alt_q[ROW4_ALT_BIT] |=>
            row4_oe_out && (row4_pin_out == $past(reset_gen_in)))
        else $error("row 4 does not carry the reset output");

    a_col1_gpio: assert property ( // see (R4)
        !pin_alt_q[COL1_ALT_BIT] |=>
            (col1_pin_out == $past(gpio8_data_in)) &&
            (col1_oe_out == $past(gpio8_oe_in)))
        else $error("column 1 left its general-purpose role");

    a_row3_input: assert property ( // see (R5)
        pin_alt_q[ROW3_ALT_BIT] |=>
            !row3_oe_out && (logic_input_c_out == $past(row3_pin_in)))
        else $error("row 3 does not feed logic input C");

    a_row0_logic: assert property ( // see (R6)
        pin_alt_q[ROW0_ALT_BIT] |=>
            row0_oe_out && (row0_pin_out == $past(logic_output_y_in)))
        else $error("row 0 does not carry logic output Y");

    a_osc_off_quiet: assert property ( // see (R7)
        !general_q[OSC_ON_BIT] |=> !core_tick_out)
        else $error("core tick while the oscillator is off");

    a_tick_slowest: assert property ( // see (R8)
        core_tick_out && ($past(clk_sel) == 2'h0) |->
            $past(tick_cnt_q) == 9'h18F)
        else $error("slowest core tick not 400 cycles apart");

    a_soft_reset: assert property ( // see (R9)
        wr_general && reg_wdata_in[SOFT_RESET_BIT] |->
            ##2 core_reset_out && (general_q == 8'h00) &&
            (pin_alt_q == 8'h00) && (irq_en_q == 8'h00))
        else $error("soft reset did not clear the bank");

    a_release_window: assert property ( // see (R11)
        release_start |=> int_n_out [*4])
        else $error("interrupt pin not released after clear");

    a_hold_on_clear: assert property ( // see (R11)
        wr_irq_clr && pending && !general_q[RELEASE_ON_CLEAR_BIT] &&
            !release_busy |=> !int_n_out)
        else $error("interrupt pin dropped while still pending");

    a_pin_reset: assert property ( // see (R12)
        !reset_pin_n_in && !general_q[RESET_PIN_IGNORE_BIT] |=>
            core_reset_out && (general_q == 8'h00))
        else $error("reset pin low did not reset the bank");

    a_pin_ignored: assert property ( // see (R12)
        !reset_pin_n_in && general_q[RESET_PIN_IGNORE_BIT] &&
            !soft_reset_bit_q |=> !core_reset_out)
        else $error("reset pin acted while set to be ignored");

    a_irq_gating: assert property ( // see (R13) (R14) (R15) (R16) (R17)
        !$past(release_busy) |->
            int_n_out == !(|(status_q & irq_en_q)))
        else $error("interrupt pin disagrees with enabled flags");

    a_reserved_zero: assert property ( // see (R18)
        reg_rd_in && (reg_addr_in == ADDR_PIN_ALT) |=>
            (reg_rdata_out & ~PIN_ALT_MASK) == 8'h00)
        else $error("reserved bit read back as one");

    a_set_wins: assert property (
        key_event_irq_in && wr_irq_clr && !sreset |=>
            status_q[EVENT_IRQ_BIT])
        else $error("event lost to a simultaneous clear");

    c_soft_reset: cover property (soft_reset_bit_q);
    c_release: cover property (release_start ##1 int_n_out);
    c_col0_pulse: cover property (pin_alt_q[COL0_ALT_BIT] && col0_pin_out);
    c_irq_asserted: cover property (!int_n_out && irq_en_q[LOGIC_IRQ_BIT]);

endmodule

`default_nettype wire

// ===== verification/host_model.sv
/* Host side of the register port: write, read and soft-reset tasks.
   Assumes it shares the device's clock and is the only bus master. */
`timescale 1ns/1ps
`default_nettype none
module host_model
    import pin_osc_irq_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic [7:0] rdata_in,
    output logic [7:0] addr_out,
    output logic [7:0] wdata_out,
    output logic wr_out,
    output logic rd_out
);
    localparam int WAIT_CYC = SOFT_RESET_WAIT_US * (CLK_HZ / 1_000_000);
    initial
    begin
        addr_out = 8'h00;
        wdata_out = 8'h00;
        wr_out = 1'b0;
        rd_out = 1'b0;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk_in);
        addr_out <= a;
        wdata_out <= d;
        wr_out <= 1'b1;
        @(posedge core_clk_in);
        wr_out <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk_in);
        addr_out <= a;
        rd_out <= 1'b1;
        @(posedge core_clk_in);
        rd_out <= 1'b0;
        #1;
        d = rdata_in;
    endtask
    // No further writes until the device has settled
    task automatic soft_reset();
        wr(ADDR_GENERAL, 8'h04);
        repeat (WAIT_CYC) @(posedge core_clk_in);
    endtask
endmodule
`default_nettype wire

// ===== verification/test_pin_osc_irq_config_regs.sv
/* Self-checking bench of the configuration bank.
   Assumes the host model drives the register port. */
`timescale 1ns/1ps
`default_nettype none
module test_pin_osc_irq_config_regs;
    import pin_osc_irq_pkg::*;
    localparam int RC = 4;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic pin_n = 1'b1;
    logic [4:0] ev = 5'h00;
    logic [4:0] gd = 5'h00;
    logic [3:0] alt = 4'h0;
    logic r3 = 1'b0;
    logic seen_rst = 1'b0;
    logic [7:0] addr, wdata, rdata;
    logic wr, rd, lc, g4, pull, osc, tick, crst, int_n;
    logic [3:0] pins;
    logic [5:0] oes;
    int mismatches = 0;
    int samples_checked = 0;
    int ticks = 0;
    always #25 clk = ~clk;
    always @(posedge clk)
    begin
        if (tick === 1'b1) ticks++;
        if (crst === 1'b1) seen_rst = 1'b1;
    end
    host_model host_u (.core_clk_in(clk), .rdata_in(rdata), .addr_out(addr),
        .wdata_out(wdata), .wr_out(wr), .rd_out(rd));
    pin_osc_irq_config_regs #(.RELEASE_COUNT(RC)) dut_u (
        .core_clk_in(clk), .rst_in(rst), .reset_pin_n_in(pin_n),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
        .reg_rd_in(rd), .reg_rdata_out(rdata),
        .logic_irq_event_in(ev[4]), .overflow_irq_event_in(ev[2]),
        .input_change_irq_event_in(ev[1]), .key_event_irq_in(ev[0]),
        .gpio1_data_in(gd[4]), .gpio1_oe_in(gd[4]),
        .logic_output_y_in(alt[3]), .gpio4_data_in(gd[3]),
        .gpio4_oe_in(gd[3]), .row3_pin_in(r3),
        .gpio5_data_in(gd[2]), .gpio5_oe_in(gd[2]), .reset_gen_in(alt[2]),
        .gpio7_data_in(gd[1]), .gpio7_oe_in(gd[1]),
        .pulse_output_one_in(alt[1]), .gpio8_data_in(gd[0]),
        .gpio8_oe_in(gd[0]), .pulse_output_two_in(alt[0]),
        .row0_pin_out(pins[3]), .row0_oe_out(oes[4]),
        .row3_pin_out(oes[5]), .row3_oe_out(oes[3]),
        .row4_pin_out(pins[2]), .row4_oe_out(oes[2]),
        .col0_pin_out(pins[1]), .col0_oe_out(oes[1]),
        .col1_pin_out(pins[0]), .col1_oe_out(oes[0]),
        .logic_input_c_out(lc), .gpio4_in_out(g4),
        .row_pull_100k_out(pull), .oscillator_on_out(osc),
        .core_tick_out(tick), .core_reset_out(crst), .int_n_out(int_n));
    task automatic check(input logic [7:0] s, input logic [7:0] e);
        samples_checked++;
        if (s !== e)
        begin
            mismatches++;
            $display("ERROR %0t: saw %h want %h", $time, s, e);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] v;
        host_u.rd(a, v);
        check(v, e);
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic pulse(input logic [4:0] m);
        @(posedge clk);
        ev <= m;
        @(posedge clk);
        ev <= 5'h00;
        #1;
    endtask
    task automatic t_regs();
        rchk(ADDR_PIN_ALT, PIN_ALT_RESET);
        rchk(ADDR_IRQ_ENABLE, IRQ_ENABLE_RESET);
        host_u.wr(ADDR_PIN_ALT, 8'hFF);
        host_u.wr(ADDR_GENERAL, 8'hFB);
        host_u.wr(ADDR_IRQ_ENABLE, 8'hFF);
        rchk(ADDR_PIN_ALT, 8'hF9);
        rchk(ADDR_GENERAL, 8'hE3);
        rchk(ADDR_IRQ_ENABLE, 8'h17);
        rchk(8'h55, 8'h00);
        check(pull, 8'h01);
        check(osc, 8'h01);
        // Whole periods make the count phase-free
        ticks = 0;
        step(200);
        check(ticks, 8'h04);
        host_u.wr(ADDR_GENERAL, 8'hA3);
        step(1);
        ticks = 0;
        step(400);
        check(ticks, 8'h02);
        host_u.wr(ADDR_GENERAL, 8'h83);
        step(1);
        ticks = 0;
        step(800);
        check(ticks, 8'h02);
    endtask
    task automatic t_pins();
        alt <= 4'hF;
        r3 <= 1'b1;
        step(3);
        check(pins, 8'h0F);
        check({lc, g4}, 8'h02);
        check(oes, 8'h17);
        host_u.wr(ADDR_PIN_ALT, 8'h00);
        alt <= 4'h0;
        gd <= 5'h1F;
        step(3);
        check(pins, 8'h0F);
        check({lc, g4}, 8'h01);
        check(oes, 8'h3F);
    endtask
    task automatic t_irq();
        logic [4:0] m;
        for (int i = 0; i < 4; i++)
        begin
            m = (i == 0) ? 5'h10 : 5'h01 << (3 - i);
            host_u.wr(ADDR_IRQ_CLEAR, 8'h17);
            host_u.wr(ADDR_IRQ_ENABLE, IRQ_MASK ^ m);
            pulse(m);
            step(1);
            check(int_n, 8'h01);
            host_u.wr(ADDR_IRQ_ENABLE, m);
            step(1);
            check(int_n, 8'h00);
        end
        host_u.wr(ADDR_IRQ_ENABLE, 8'h17);
        pulse(5'h04);
        rchk(ADDR_IRQ_STATUS, 8'h05);
        host_u.wr(ADDR_IRQ_CLEAR, 8'h01);
        step(1);
        check(int_n, 8'h01);
        step(RC + 2);
        check(int_n, 8'h00);
        host_u.wr(ADDR_GENERAL, 8'h01);
        pulse(5'h01);
        host_u.wr(ADDR_IRQ_CLEAR, 8'h01);
        step(1);
        check(int_n, 8'h00);
    endtask
    task automatic t_reset();
        host_u.wr(ADDR_PIN_ALT, 8'h40);
        seen_rst = 1'b0;
        pin_n <= 1'b0;
        step(4);
        pin_n <= 1'b1;
        rchk(ADDR_PIN_ALT, 8'h40);
        check(seen_rst, 8'h00);
        host_u.wr(ADDR_GENERAL, 8'h00);
        pin_n <= 1'b0;
        step(4);
        pin_n <= 1'b1;
        rchk(ADDR_PIN_ALT, 8'h00);
        check(seen_rst, 8'h01);
        host_u.wr(ADDR_PIN_ALT, 8'h40);
        seen_rst = 1'b0;
        host_u.soft_reset();
        check(seen_rst, 8'h01);
        rchk(ADDR_PIN_ALT, 8'h00);
    endtask
    task automatic report_and_stop();
        $display("mismatches=%0d samples_checked=%0d", mismatches,
            samples_checked);
        if (mismatches == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_pins();
        t_irq();
        t_reset();
        report_and_stop();
    end
    initial
    begin
        #(20000 * 50);
        mismatches++;
        report_and_stop();
    end
endmodule
`default_nettype wire
